// ---- pmkd_pkg.sv ----
// Package for the power mode key decoder: key codes, flag layout and states.
// Assumes it is compiled before every other file of the block.
`default_nettype none
package pmkd_pkg;
    localparam int unsigned KEY_W = 8;
    localparam logic [7:0] KEY_NOP0 = 8'h00;
    localparam logic [7:0] KEY_IDLE = 8'h01;
    localparam logic [7:0] KEY_PDOWN = 8'h02;
    localparam logic [7:0] KEY_NOP3 = 8'h03;
    localparam int unsigned FLAG_W = 6;
    localparam int unsigned FLAG_Z = 5;
    localparam int unsigned FLAG_N = 4;
    localparam int unsigned FLAG_C = 3;
    localparam int unsigned FLAG_V = 2;
    localparam int unsigned FLAG_OVTRAP = 1;
    localparam int unsigned FLAG_STICKY = 0;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [5:0] FLAGS_CLR = 6'h00;
    typedef enum logic [1:0] {
        PMKD_NONE = 2'b00,
        PMKD_IDLE = 2'b01,
        PMKD_PDOWN = 2'b10,
        PMKD_RESET = 2'b11
    } pmkd_act_e;
    typedef enum logic [1:0] {
        PMKD_STATE_READY = 2'b00,
        PMKD_STATE_WAIT = 2'b01,
        PMKD_STATE_DONE = 2'b10
    } pmkd_state_e;
endpackage : pmkd_pkg
`default_nettype wire

// ---- pmkd_classify.sv ----
// Registered classifier that maps an 8-bit key to an action.
// Assumes a single clock domain shared with the decoder top.
`default_nettype none
module pmkd_classify (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // Key in, action out.
    input wire logic load_i,
    input wire logic [7:0] key_i,
    output logic [1:0] act_o
);
    logic [1:0] act_reg;
    logic [1:0] act_next;

    always_comb begin
        act_next = act_reg;
        if (load_i) begin
            if (key_i == pmkd_pkg::KEY_IDLE) begin
                act_next = pmkd_pkg::PMKD_IDLE;
            end else if (key_i == pmkd_pkg::KEY_PDOWN) begin
                act_next = pmkd_pkg::PMKD_PDOWN;
            end else if (key_i > pmkd_pkg::KEY_NOP3) begin
                act_next = pmkd_pkg::PMKD_RESET;
            end else begin
                act_next = pmkd_pkg::PMKD_NONE;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            act_reg <= pmkd_pkg::PMKD_NONE;
        end else if (clk_en_i) begin
            act_reg <= act_next;
        end
    end

    assign act_o = act_reg;
endmodule // pmkd_classify
`default_nettype wire

// ---- pmkd_top.sv ----
// Power mode key decoder for the idle/powerdown instruction.
// Assumes the pipeline and bus controller share clock_i; key held with its strobe.
// Contract
// - The key is an 8-bit value and alone selects the action.
// - Key 1 stops the CPU and enters idle mode.
// - Key 2 enters powerdown mode.
// - Keys above 3 are illegal and start a full reset sequence.
// - Key 3 is not illegal and never resets the device.
// - Any prefetch in progress finishes before halt or reset begins.
// - Reset keys clear all six status flags; keys 1 and 2 keep them.
`default_nettype none
module pmkd_top (
    // Clock, reset and enable.
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // Instruction from the execution pipeline.
    input wire logic instr_valid_i,
    input wire logic [7:0] key_i,
    input wire logic [5:0] flags_i,
    // Bus controller status.
    input wire logic prefetch_busy_i,
    // Results.
    output logic done_o,
    output logic idle_o,
    output logic powerdown_o,
    output logic reset_req_o,
    output logic flags_we_o,
    output logic [5:0] flags_o
);
    pmkd_pkg::pmkd_state_e state_reg;
    pmkd_pkg::pmkd_state_e state_next;
    logic load;
    logic [1:0] act;
    logic done_reg;
    logic done_next;
    logic idle_reg;
    logic idle_next;
    logic pd_reg;
    logic pd_next;
    logic rst_reg;
    logic rst_next;
    logic fwe_reg;
    logic fwe_next;
    logic [5:0] flags_reg;
    logic [5:0] flags_next;

    // A key is taken from READY and from DONE alike, so the classifier loads in both.
    assign load = instr_valid_i && (state_reg == pmkd_pkg::PMKD_STATE_READY
        || state_reg == pmkd_pkg::PMKD_STATE_DONE);

    // The whole 8-bit key is decoded and registered as a 2-bit action in the classifier.
    pmkd_classify u_classify (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .load_i(load),
        .key_i(key_i),
        .act_o(act)
    );

    always_comb begin
        state_next = state_reg;
        done_next = 1'b0;
        idle_next = idle_reg;
        pd_next = pd_reg;
        rst_next = rst_reg;
        fwe_next = 1'b0;
        flags_next = flags_reg;
        case (state_reg)
            pmkd_pkg::PMKD_STATE_READY: begin
                if (instr_valid_i) begin
                    flags_next = flags_i;
                    state_next = pmkd_pkg::PMKD_STATE_WAIT;
                end
            end
            pmkd_pkg::PMKD_STATE_WAIT: begin
                if (!prefetch_busy_i) begin
                    done_next = 1'b1;
                    state_next = pmkd_pkg::PMKD_STATE_DONE;
                    case (act)
                        pmkd_pkg::PMKD_IDLE: idle_next = 1'b1;
                        pmkd_pkg::PMKD_PDOWN: pd_next = 1'b1;
                        pmkd_pkg::PMKD_RESET: begin
                            rst_next = 1'b1;
                            fwe_next = 1'b1;
                            flags_next = pmkd_pkg::FLAGS_CLR;
                        end
                        default: state_next = pmkd_pkg::PMKD_STATE_READY;
                    endcase
                end
            end
            pmkd_pkg::PMKD_STATE_DONE: begin
                // Mode outputs hold until the next instruction strobe.
                if (instr_valid_i) begin
                    idle_next = 1'b0;
                    pd_next = 1'b0;
                    rst_next = 1'b0;
                    flags_next = flags_i;
                    state_next = pmkd_pkg::PMKD_STATE_WAIT;
                end
            end
            default: state_next = pmkd_pkg::PMKD_STATE_READY;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state_reg <= pmkd_pkg::PMKD_STATE_READY;
            done_reg <= 1'b0;
            idle_reg <= 1'b0;
            pd_reg <= 1'b0;
            rst_reg <= 1'b0;
            fwe_reg <= 1'b0;
            flags_reg <= pmkd_pkg::FLAGS_RST;
        end else if (clk_en_i) begin
            state_reg <= state_next;
            done_reg <= done_next;
            idle_reg <= idle_next;
            pd_reg <= pd_next;
            rst_reg <= rst_next;
            fwe_reg <= fwe_next;
            flags_reg <= flags_next;
        end
    end

    assign done_o = done_reg;
    assign idle_o = idle_reg;
    assign powerdown_o = pd_reg;
    assign reset_req_o = rst_reg;
    assign flags_we_o = fwe_reg;
    assign flags_o = flags_reg;

    // Every property below samples on the core clock and rests while reset is held.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    chk_key_idle: assert property (
        load && clk_en_i && key_i == pmkd_pkg::KEY_IDLE && !prefetch_busy_i
        ##1 clk_en_i && !prefetch_busy_i |=> idle_o)
        else $error("Key 1 did not enter idle.");

    chk_key_pdown: assert property (
        load && clk_en_i && key_i == pmkd_pkg::KEY_PDOWN && !prefetch_busy_i
        ##1 clk_en_i && !prefetch_busy_i |=> powerdown_o)
        else $error("Key 2 did not enter powerdown.");

    chk_key_reset: assert property (
        load && clk_en_i && key_i > pmkd_pkg::KEY_NOP3 && !prefetch_busy_i
        ##1 clk_en_i && !prefetch_busy_i |=> reset_req_o && flags_o == pmkd_pkg::FLAGS_CLR)
        else $error("Illegal key did not reset.");

    chk_key3_safe: assert property (
        load && clk_en_i && key_i == pmkd_pkg::KEY_NOP3 |=> !reset_req_o [*3])
        else $error("Key 3 caused a reset.");

    chk_prefetch_wait: assert property (
        state_reg == pmkd_pkg::PMKD_STATE_WAIT && prefetch_busy_i
        |=> !$rose(idle_o) && !$rose(powerdown_o) && !$rose(reset_req_o))
        else $error("Action taken during prefetch.");

    chk_busy_stall: assert property (
        state_reg == pmkd_pkg::PMKD_STATE_WAIT && prefetch_busy_i && clk_en_i |=> !done_o)
        else $error("Done raised during prefetch.");

    chk_done_after_wait: assert property (
        state_reg == pmkd_pkg::PMKD_STATE_WAIT && !prefetch_busy_i && clk_en_i |=> done_o)
        else $error("Done missing after prefetch ended.");

    chk_done_pulse: assert property (
        done_o && clk_en_i |=> !done_o)
        else $error("Done held for more than one cycle.");

    chk_key_held: assert property (
        state_reg == pmkd_pkg::PMKD_STATE_WAIT |=> $stable(act))
        else $error("Key action changed while waiting.");

    chk_flags_clear: assert property (
        $rose(flags_we_o) |-> flags_o == pmkd_pkg::FLAGS_CLR && reset_req_o)
        else $error("Flags written without reset.");

    chk_reset_flags: assert property (
        $rose(reset_req_o) |-> flags_we_o && done_o)
        else $error("Reset raised without a flag write.");

    chk_mode_noflag: assert property (
        $rose(idle_o) || $rose(powerdown_o) |-> !flags_we_o)
        else $error("Flags written for mode key.");

    chk_flags_keep: assert property (
        done_o && !reset_req_o |-> !flags_we_o)
        else $error("Flags written without a reset key.");

    chk_nop_keys: assert property (
        load && clk_en_i && key_i == pmkd_pkg::KEY_NOP0 && !prefetch_busy_i
        ##1 clk_en_i && !prefetch_busy_i
        |=> done_o && !idle_o && !powerdown_o && !reset_req_o && !flags_we_o)
        else $error("Key 0 was not a no-operation.");

    chk_mode_clear: assert property (
        load && clk_en_i |=> !idle_o && !powerdown_o && !reset_req_o)
        else $error("Mode output survived a new key.");

    chk_idle_hold: assert property (
        idle_o && !(load && clk_en_i) |=> idle_o)
        else $error("Idle dropped without a new key.");

    chk_pdown_hold: assert property (
        powerdown_o && !(load && clk_en_i) |=> powerdown_o)
        else $error("Powerdown dropped without a new key.");

    chk_reset_hold: assert property (
        reset_req_o && !(load && clk_en_i) |=> reset_req_o)
        else $error("Reset request dropped without a new key.");

    chk_one_mode: assert property (
        !(idle_o && powerdown_o) && !(idle_o && reset_req_o) && !(powerdown_o && reset_req_o))
        else $error("Two actions at once.");

    chk_enable_freeze: assert property (
        !clk_en_i |=> $stable(done_o) && $stable(idle_o) && $stable(powerdown_o)
        && $stable(reset_req_o) && $stable(flags_we_o) && $stable(flags_o))
        else $error("State moved while the enable was low.");

    cov_idle: cover property ($rose(idle_o));
    cov_pdown: cover property ($rose(powerdown_o));
    cov_reset: cover property ($rose(reset_req_o));
    cov_nop: cover property (done_o && !idle_o && !powerdown_o && !reset_req_o);
    cov_stall: cover property ((state_reg == pmkd_pkg::PMKD_STATE_WAIT && prefetch_busy_i) [*3]);
endmodule // pmkd_top
`default_nettype wire

// ---- pmkd_bus_model.sv ----
// Bus controller model: holds prefetch busy for a requested number of cycles.
// Assumes start_i is raised for one cycle, off the rising edge.
`default_nettype none
module pmkd_bus_model (
    // Clock.
    input wire logic clock_i,
    // Stall request.
    input wire logic start_i,
    input wire logic [3:0] len_i,
    // Prefetch status.
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] left_reg = 4'h0;
    // Counts down the cycles of the prefetch still in flight.
    always_ff @(posedge clock_i) begin
        if (start_i) begin
            left_reg <= len_i;
        end else if (left_reg != 4'h0) begin
            left_reg <= left_reg - 4'h1;
        end
    end
    assign busy_o = (left_reg != 4'h0);
endmodule // pmkd_bus_model
`default_nettype wire

// ---- test_power_mode_key_decode.sv ----
// Self-checking bench for the power mode key decoder.
// Assumes pmkd_pkg, pmkd_top and pmkd_bus_model are compiled first.
`default_nettype none
`define CHECK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin \
    num_errors++; $display("wrong value at %0t: %s", $time, msg); end end
module test_power_mode_key_decode;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [7:0] key_i = 8'h00;
    logic [5:0] flags_i = 6'h00;
    logic stall_go = 1'b0;
    logic [3:0] stall_len = 4'h0;
    logic prefetch_busy_i;
    logic done_o, idle_o, powerdown_o, reset_req_o, flags_we_o;
    logic [5:0] flags_o;
    int num_errors = 0;
    int comparisons = 0;
    always #2 clock_i = ~clock_i;
    pmkd_top u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
        .instr_valid_i(instr_valid_i), .key_i(key_i), .flags_i(flags_i),
        .prefetch_busy_i(prefetch_busy_i), .done_o(done_o), .idle_o(idle_o),
        .powerdown_o(powerdown_o), .reset_req_o(reset_req_o),
        .flags_we_o(flags_we_o), .flags_o(flags_o));
    pmkd_bus_model u_bus (.clock_i(clock_i), .start_i(stall_go), .len_i(stall_len),
        .busy_o(prefetch_busy_i));
    task automatic end_of_test();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Issues one key with a prefetch stall, then a stray request while waiting.
    task automatic run_key(input logic [7:0] key, input logic [3:0] stall);
        int n;
        n = 1;
        @(negedge clock_i);
        instr_valid_i = 1'b1;
        key_i = key;
        flags_i = 6'h2D;
        stall_go = 1'b1;
        stall_len = stall;
        @(negedge clock_i);
        stall_go = 1'b0;
        key_i = ~key;
        @(negedge clock_i);
        instr_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 20) begin
            @(negedge clock_i);
            n++;
        end
        `CHECK(n, 1 + stall, "completion latency")
        `CHECK(idle_o, key == 8'h01, "idle mode")
        `CHECK(powerdown_o, key == 8'h02, "powerdown mode")
        `CHECK(reset_req_o, key > 8'h03, "reset request")
        `CHECK(flags_we_o, key > 8'h03, "flag write")
        if (key > 8'h03) `CHECK(flags_o, 6'h00, "flags cleared")
        @(negedge clock_i);
        `CHECK(done_o, 1'b0, "done is a pulse")
        `CHECK(idle_o, key == 8'h01, "idle mode held")
    endtask
    task automatic test_modes();
        run_key(8'h01, 4'h0);
        run_key(8'h02, 4'h0);
    endtask
    task automatic test_nop_keys();
        run_key(8'h00, 4'h0);
        run_key(8'h03, 4'h2);
    endtask
    task automatic test_illegal_keys();
        run_key(8'h04, 4'h0);
        run_key(8'hFF, 4'h1);
        run_key(8'h80, 4'h0);
    endtask
    task automatic test_prefetch_stall();
        run_key(8'h01, 4'h5);
        run_key(8'h05, 4'h3);
    endtask
    // Freezing the enable during a wait delays completion by the frozen cycles.
    task automatic test_clock_enable();
        @(negedge clock_i);
        instr_valid_i = 1'b1;
        key_i = 8'h01;
        @(negedge clock_i);
        instr_valid_i = 1'b0;
        clk_en_i = 1'b0;
        repeat (3) begin
            @(negedge clock_i);
            `CHECK(done_o, 1'b0, "done while disabled")
        end
        clk_en_i = 1'b1;
        @(negedge clock_i);
        `CHECK(done_o, 1'b1, "done after enable returns")
        `CHECK(idle_o, 1'b1, "idle after enable returns")
        `CHECK(reset_req_o, 1'b0, "reset request cleared by key")
    endtask
    // A reset in mid-run drops a held mode output, and the next key is taken normally.
    task automatic test_reset_clears();
        run_key(8'h02, 4'h0);
        resetn_i = 1'b0;
        @(negedge clock_i);
        resetn_i = 1'b1;
        `CHECK(powerdown_o, 1'b0, "reset clears mode")
        run_key(8'h01, 4'h0);
    endtask
    initial begin
        repeat (5) @(negedge clock_i);
        resetn_i = 1'b1;
        test_modes();
        test_nop_keys();
        test_illegal_keys();
        test_prefetch_stall();
        test_clock_enable();
        test_reset_clears();
        end_of_test();
    end
    // Cuts a hang short well after the 67 cycles the tests need.
    initial begin
        repeat (2000) @(posedge clock_i);
        num_errors++;
        end_of_test();
    end
endmodule // test_power_mode_key_decode
`default_nettype wire
